// ===== pkg/pfc_trim_pkg.sv
// Constants and types shared by the protection and trim register group
package pfc_trim_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [15:0] FAST_OC_SETTING_ADDR   = 16'hfe3e;
  localparam logic [15:0] TEMP_HYSTERESIS_ADDR   = 16'hfe3f;
  localparam logic [15:0] LINE_GAIN_TRIM_ADDR    = 16'hfe40;
  localparam logic [15:0] OUTPUT_GAIN_TRIM_ADDR  = 16'hfe41;
  localparam logic [15:0] CURRENT_GAIN_TRIM_ADDR = 16'hfe42;
  localparam logic [15:0] PHASE_BAL_GAIN_ADDR    = 16'hfe43;
  localparam logic [15:0] LOW_POWER_THRESH_ADDR  = 16'hfe44;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  FAST_OC_SETTING_RST   = 8'h00;
  localparam logic [7:0]  TEMP_HYSTERESIS_RST   = 8'h00;
  localparam logic [7:0]  GAIN_TRIM_RST         = 8'h00;
  localparam logic [7:0]  PHASE_BAL_GAIN_RST    = 8'h00;
  localparam logic [12:0] LOW_POWER_THRESH_RST  = 13'h0000;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int          LIMIT_MSB         = 7;
  localparam int          LIMIT_LSB         = 5;
  localparam int          SENSE_NEG_BIT     = 7;
  localparam int          RANGE_SEL_BIT     = 1;
  localparam int          REF_SEL_BIT       = 0;
  localparam logic [7:0]  FAST_OC_WR_MASK   = 8'he3;
  localparam int          TRIM_SIGN_BIT     = 7;
  localparam int          BAL_ENABLE_BIT    = 7;
  localparam int          LOW_POWER_W       = 13;
  localparam int          TRIM_SHIFT        = 10;

  // Current limit value in microamps per code
  localparam logic [6:0]  LIMIT_UA_TABLE [8] = '{
    7'd20, 7'd40, 7'd60, 7'd80, 7'd60, 7'd80, 7'd100, 7'd120
  };

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_PERIOD_NS     = 8;
  localparam int          DEBOUNCE_NS [4]   = '{40, 80, 120, 240};
  localparam int          DEBOUNCE_CYC [4]  = '{
    (DEBOUNCE_NS[0] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    (DEBOUNCE_NS[1] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    (DEBOUNCE_NS[2] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    (DEBOUNCE_NS[3] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
  };

  // ****************************************
  // Overcurrent state machine
  // ****************************************
  typedef enum logic [2:0] {
    OC_IDLE     = 3'b001,
    OC_DEBOUNCE = 3'b010,
    OC_TRIPPED  = 3'b100
  } oc_state_t;

endpackage : pfc_trim_pkg

// ===== pkg/trim_if.sv
// Carrier between the register group and one gain trim path
`timescale 1ns/1ps
interface trim_if #(parameter int W = 12);
  logic [W-1:0] sample;
  logic         sample_valid;
  logic [7:0]   trim;
  logic [W-1:0] result;
  logic         result_valid;

  modport trimmer (input sample, input sample_valid, input trim,
                   output result, output result_valid);
  modport user    (output sample, output sample_valid, output trim,
                   input result, input result_valid);
endinterface : trim_if

// ===== logic/gain_trimmer.sv
// One measurement path gain correction stage
`timescale 1ns/1ps
module gain_trimmer
  import pfc_trim_pkg::*;
#(
  parameter int W = 12
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  trim_if.trimmer     tp
);

  logic [6:0]   mag;
  logic [W+6:0] prod;
  logic [W:0]   corr;
  logic [W:0]   sum_nxt;
  logic [W:0]   diff_nxt;

  assign mag      = tp.trim[6:0];
  assign prod     = (W+7)'(tp.sample) * (W+7)'(mag);
  assign corr     = (W+1)'(prod >> TRIM_SHIFT);
  assign sum_nxt  = {1'b0, tp.sample} + corr;
  assign diff_nxt = {1'b0, tp.sample} - corr;

  // ****************************************
  // Corrected sample, saturated at both ends
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tp.result       <= '0;
      tp.result_valid <= 1'b0;
    end else begin
      tp.result_valid <= tp.sample_valid;
      if (tp.sample_valid) begin
        if (tp.trim[TRIM_SIGN_BIT]) begin
          tp.result <= diff_nxt[W] ? '0 : diff_nxt[W-1:0];
        end else begin
          tp.result <= sum_nxt[W] ? '1 : sum_nxt[W-1:0];
        end
      end
    end
  end

endmodule : gain_trimmer

// ===== logic/pfc_protection_trim_regs.sv
// Protection, trim, phase balance and low power threshold register group
`timescale 1ns/1ps
module pfc_protection_trim_regs
  import pfc_trim_pkg::*;
#(
  parameter int ADC_W   = 12,
  parameter int TEMP_W  = 12,
  parameter int PHASE_W = 12,
  parameter int INTEG_W = 24,
  parameter int VOUT_W  = 11
) (
  input  wire logic                CLK,
  input  wire logic                RST_N,
  input  wire logic [15:0]         REG_ADDR,
  input  wire logic [15:0]         REG_WDATA,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  output      logic [15:0]         REG_RDATA,
  output      logic                REG_RVALID,
  output      logic                REG_WR_REFUSED,
  input  wire logic                TRIM_UNLOCK,
  input  wire logic                CS_ABOVE_LIMIT,
  input  wire logic                SWITCH_CYCLE_START,
  input  wire logic [1:0]          DEBOUNCE_SEL,
  output      logic                SWITCH_DISABLE,
  output      logic                SENSE_NEGATIVE,
  output      logic [6:0]          CURRENT_LIMIT_UA,
  output      logic                CS_RANGE_500MV,
  output      logic                LEVEL_SHIFT_REF_EXT,
  input  wire logic [TEMP_W-1:0]   THERMAL_SENSOR,
  input  wire logic                THERMAL_VALID,
  input  wire logic [TEMP_W-1:0]   TEMP_FAULT_LIMIT,
  input  wire logic [TEMP_W-1:0]   TEMP_WARNING_LIMIT,
  output      logic                OVERTEMP_FAULT_FLAG,
  output      logic                OVERTEMP_WARNING_FLAG,
  input  wire logic [ADC_W-1:0]    LINE_SAMPLE,
  input  wire logic [ADC_W-1:0]    OUTPUT_SAMPLE,
  input  wire logic [ADC_W-1:0]    CURRENT_SAMPLE,
  input  wire logic                SAMPLE_VALID,
  output      logic [ADC_W-1:0]    LINE_TRIMMED,
  output      logic [ADC_W-1:0]    OUTPUT_TRIMMED,
  output      logic [ADC_W-1:0]    CURRENT_TRIMMED,
  output      logic                TRIMMED_VALID,
  input  wire logic [PHASE_W-1:0]  PHASE_A_CURRENT,
  input  wire logic [PHASE_W-1:0]  PHASE_B_CURRENT,
  input  wire logic                BALANCE_SAMPLE,
  output      logic [INTEG_W-1:0]  BALANCE_CORRECTION,
  output      logic                BALANCE_ACTIVE,
  input  wire logic                SMART_VOUT_EN,
  input  wire logic [LOW_POWER_W-1:0] INPUT_POWER,
  input  wire logic [7:0]          POWER_HYSTERESIS,
  input  wire logic                HIGH_LINE,
  input  wire logic [VOUT_W-1:0]   LOW_LINE_LOW_POWER_TARGET,
  input  wire logic [VOUT_W-1:0]   HIGH_LINE_LOW_POWER_TARGET,
  output      logic                LOW_POWER_MODE,
  output      logic [VOUT_W-1:0]   LOW_POWER_TARGET
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0]             fast_oc_r;
  logic [7:0]             temp_hys_r;
  logic [7:0]             line_trim_r;
  logic [7:0]             output_trim_r;
  logic [7:0]             current_trim_r;
  logic [7:0]             bal_gain_r;
  logic [LOW_POWER_W-1:0] low_power_r;

  logic                   is_trim_addr;
  logic                   wr_ok;

  assign is_trim_addr = (REG_ADDR == LINE_GAIN_TRIM_ADDR)
                      || (REG_ADDR == OUTPUT_GAIN_TRIM_ADDR)
                      || (REG_ADDR == CURRENT_GAIN_TRIM_ADDR);
  assign wr_ok        = REG_WR && (!is_trim_addr || TRIM_UNLOCK);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fast_oc_r      <= FAST_OC_SETTING_RST;
      temp_hys_r     <= TEMP_HYSTERESIS_RST;
      line_trim_r    <= GAIN_TRIM_RST;
      output_trim_r  <= GAIN_TRIM_RST;
      current_trim_r <= GAIN_TRIM_RST;
      bal_gain_r     <= PHASE_BAL_GAIN_RST;
      low_power_r    <= LOW_POWER_THRESH_RST;
    end else if (wr_ok) begin
      unique case (REG_ADDR)
        FAST_OC_SETTING_ADDR:   fast_oc_r <= REG_WDATA[7:0] & FAST_OC_WR_MASK;
        TEMP_HYSTERESIS_ADDR:   temp_hys_r <= REG_WDATA[7:0];
        LINE_GAIN_TRIM_ADDR:    line_trim_r <= REG_WDATA[7:0];
        OUTPUT_GAIN_TRIM_ADDR:  output_trim_r <= REG_WDATA[7:0];
        CURRENT_GAIN_TRIM_ADDR: current_trim_r <= REG_WDATA[7:0];
        PHASE_BAL_GAIN_ADDR:    bal_gain_r <= REG_WDATA[7:0];
        LOW_POWER_THRESH_ADDR:  low_power_r <= REG_WDATA[LOW_POWER_W-1:0];
        default: ;
      endcase
    end
  end

  // Locked trim write reported as a pulse
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REG_WR_REFUSED <= 1'b0;
    end else begin
      REG_WR_REFUSED <= REG_WR && is_trim_addr && !TRIM_UNLOCK;
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REG_RDATA  <= 16'h0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        unique case (REG_ADDR)
          FAST_OC_SETTING_ADDR:   REG_RDATA <= {8'h00, fast_oc_r};
          TEMP_HYSTERESIS_ADDR:   REG_RDATA <= {8'h00, temp_hys_r};
          LINE_GAIN_TRIM_ADDR:    REG_RDATA <= {8'h00, line_trim_r};
          OUTPUT_GAIN_TRIM_ADDR:  REG_RDATA <= {8'h00, output_trim_r};
          CURRENT_GAIN_TRIM_ADDR: REG_RDATA <= {8'h00, current_trim_r};
          PHASE_BAL_GAIN_ADDR:    REG_RDATA <= {8'h00, bal_gain_r};
          LOW_POWER_THRESH_ADDR:  REG_RDATA <= {3'b000, low_power_r};
          default:                REG_RDATA <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************
  // Overcurrent settings decode
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SENSE_NEGATIVE      <= 1'b0;
      CURRENT_LIMIT_UA    <= LIMIT_UA_TABLE[0];
      CS_RANGE_500MV      <= 1'b0;
      LEVEL_SHIFT_REF_EXT <= 1'b0;
    end else begin
      SENSE_NEGATIVE      <= fast_oc_r[SENSE_NEG_BIT];
      CURRENT_LIMIT_UA    <= LIMIT_UA_TABLE[fast_oc_r[LIMIT_MSB:LIMIT_LSB]];
      CS_RANGE_500MV      <= fast_oc_r[RANGE_SEL_BIT];
      LEVEL_SHIFT_REF_EXT <= fast_oc_r[REF_SEL_BIT];
    end
  end

  // ****************************************
  // Overcurrent debounce and cycle shutdown
  // ****************************************
  oc_state_t  oc_state_r;
  logic [5:0] oc_count_r;
  logic [5:0] oc_limit;

  assign oc_limit       = 6'(DEBOUNCE_CYC[DEBOUNCE_SEL]);
  assign SWITCH_DISABLE = (oc_state_r == OC_TRIPPED);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      oc_state_r <= OC_IDLE;
      oc_count_r <= 6'h00;
    end else begin
      unique case (oc_state_r)
        OC_IDLE: begin
          if (CS_ABOVE_LIMIT) begin
            oc_state_r <= OC_DEBOUNCE;
            oc_count_r <= 6'h01;
          end
        end
        OC_DEBOUNCE: begin
          if (!CS_ABOVE_LIMIT || SWITCH_CYCLE_START) begin
            oc_state_r <= OC_IDLE;
          end else if (oc_count_r >= oc_limit) begin
            oc_state_r <= OC_TRIPPED;
          end else begin
            oc_count_r <= oc_count_r + 6'h01;
          end
        end
        OC_TRIPPED: begin
          if (SWITCH_CYCLE_START) begin
            oc_state_r <= OC_IDLE;
          end
        end
        default: oc_state_r <= OC_IDLE;
      endcase
    end
  end

  // ****************************************
  // Over-temperature flags with hysteresis
  // ****************************************
  logic [TEMP_W:0] fault_release;
  logic [TEMP_W:0] warn_release;
  logic [TEMP_W:0] therm_ext;

  assign therm_ext     = {1'b0, THERMAL_SENSOR};
  assign fault_release = {1'b0, TEMP_FAULT_LIMIT} + (TEMP_W+1)'(temp_hys_r);
  assign warn_release  = {1'b0, TEMP_WARNING_LIMIT} + (TEMP_W+1)'(temp_hys_r);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      OVERTEMP_FAULT_FLAG   <= 1'b0;
      OVERTEMP_WARNING_FLAG <= 1'b0;
    end else if (THERMAL_VALID) begin
      if (THERMAL_SENSOR < TEMP_FAULT_LIMIT) begin
        OVERTEMP_FAULT_FLAG <= 1'b1;
      end else if (therm_ext > fault_release) begin
        OVERTEMP_FAULT_FLAG <= 1'b0;
      end
      if (THERMAL_SENSOR < TEMP_WARNING_LIMIT) begin
        OVERTEMP_WARNING_FLAG <= 1'b1;
      end else if (therm_ext > warn_release) begin
        OVERTEMP_WARNING_FLAG <= 1'b0;
      end
    end
  end

  // ****************************************
  // Gain trim of the three measurement paths
  // ****************************************
  logic [ADC_W-1:0] path_in  [3];
  logic [7:0]       path_trim [3];
  logic [ADC_W-1:0] path_out [3];
  logic [2:0]       path_valid;

  assign path_in[0]   = LINE_SAMPLE;
  assign path_in[1]   = OUTPUT_SAMPLE;
  assign path_in[2]   = CURRENT_SAMPLE;
  assign path_trim[0] = line_trim_r;
  assign path_trim[1] = output_trim_r;
  assign path_trim[2] = current_trim_r;

  for (genvar g = 0; g < 3; g++) begin : g_path
    trim_if #(.W(ADC_W)) tp ();
    assign tp.sample       = path_in[g];
    assign tp.sample_valid = SAMPLE_VALID;
    assign tp.trim         = path_trim[g];
    assign path_out[g]     = tp.result;
    assign path_valid[g]   = tp.result_valid;
    gain_trimmer #(.W(ADC_W)) u_trim (
      .clk   (CLK),
      .rst_n (RST_N),
      .tp    (tp)
    );
  end

  assign LINE_TRIMMED    = path_out[0];
  assign OUTPUT_TRIMMED  = path_out[1];
  assign CURRENT_TRIMMED = path_out[2];
  assign TRIMMED_VALID   = path_valid[0];

  // ****************************************
  // Phase current balance integrator
  // ****************************************
  logic signed [PHASE_W:0]   phase_diff;
  logic signed [PHASE_W+8:0] bal_step;

  assign phase_diff = $signed({1'b0, PHASE_A_CURRENT}) - $signed({1'b0, PHASE_B_CURRENT});
  assign bal_step   = phase_diff * $signed({1'b0, bal_gain_r[6:0]});
  assign BALANCE_ACTIVE = bal_gain_r[BAL_ENABLE_BIT];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      BALANCE_CORRECTION <= '0;
    end else if (!bal_gain_r[BAL_ENABLE_BIT]) begin
      BALANCE_CORRECTION <= '0;
    end else if (BALANCE_SAMPLE) begin
      BALANCE_CORRECTION <= BALANCE_CORRECTION
                          + INTEG_W'(unsigned'(INTEG_W'(bal_step)));
    end
  end

  // ****************************************
  // Smart output voltage low power mode
  // ****************************************
  logic [LOW_POWER_W:0] exit_level;

  assign exit_level = {1'b0, low_power_r} + (LOW_POWER_W+1)'(POWER_HYSTERESIS);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LOW_POWER_MODE <= 1'b0;
    end else if (!SMART_VOUT_EN) begin
      LOW_POWER_MODE <= 1'b0;
    end else if (INPUT_POWER < low_power_r) begin
      LOW_POWER_MODE <= 1'b1;
    end else if ({1'b0, INPUT_POWER} > exit_level) begin
      LOW_POWER_MODE <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LOW_POWER_TARGET <= '0;
    end else begin
      LOW_POWER_TARGET <= HIGH_LINE ? HIGH_LINE_LOW_POWER_TARGET
                                    : LOW_LINE_LOW_POWER_TARGET;
    end
  end

endmodule : pfc_protection_trim_regs

// ===== testbench/pfc_regs_properties.sv
// Concurrent checks on the ports of the protection and trim register group
`timescale 1ns/1ps
module pfc_regs_properties
  import pfc_trim_pkg::*;
#(
  parameter int TEMP_W  = 12,
  parameter int INTEG_W = 24
) (
  input wire logic               CLK,
  input wire logic               RST_N,
  input wire logic [15:0]        REG_ADDR,
  input wire logic [15:0]        REG_WDATA,
  input wire logic               REG_WR,
  input wire logic               REG_RD,
  input wire logic               REG_RVALID,
  input wire logic               REG_WR_REFUSED,
  input wire logic               TRIM_UNLOCK,
  input wire logic               CS_ABOVE_LIMIT,
  input wire logic               SWITCH_CYCLE_START,
  input wire logic               SWITCH_DISABLE,
  input wire logic               SENSE_NEGATIVE,
  input wire logic [6:0]         CURRENT_LIMIT_UA,
  input wire logic               CS_RANGE_500MV,
  input wire logic [TEMP_W-1:0]  THERMAL_SENSOR,
  input wire logic               THERMAL_VALID,
  input wire logic [TEMP_W-1:0]  TEMP_FAULT_LIMIT,
  input wire logic               OVERTEMP_FAULT_FLAG,
  input wire logic               SAMPLE_VALID,
  input wire logic               TRIMMED_VALID,
  input wire logic [INTEG_W-1:0] BALANCE_CORRECTION,
  input wire logic               BALANCE_ACTIVE,
  input wire logic               SMART_VOUT_EN,
  input wire logic               LOW_POWER_MODE
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic        trim_wr;
  logic        oc_wr;
  logic [15:0] wd1_r;
  logic [15:0] wd2_r;
  assign trim_wr = REG_WR && REG_ADDR >= LINE_GAIN_TRIM_ADDR && REG_ADDR <= CURRENT_GAIN_TRIM_ADDR;
  assign oc_wr   = REG_WR && REG_ADDR == FAST_OC_SETTING_ADDR;
  // Write data delayed to line up with decoded outputs
  always_ff @(posedge CLK) begin
    wd1_r <= REG_WDATA;
    wd2_r <= wd1_r;
  end
  function automatic logic [6:0] ua_of(input logic [2:0] c);
    return 7'h14 + 7'h14 * {5'h00, c[1:0]} + (c[2] ? 7'h28 : 7'h00);
  endfunction : ua_of
  read_answer_a: assert property (REG_RD |=> REG_RVALID)
    else $error("read not answered");
  locked_refused_a: assert property (trim_wr && !TRIM_UNLOCK |=> REG_WR_REFUSED)
    else $error("locked trim write not refused");
  unlocked_taken_a: assert property (trim_wr && TRIM_UNLOCK |=> !REG_WR_REFUSED)
    else $error("unlocked trim write refused");
  polarity_bit_a: assert property (oc_wr |-> ##2 SENSE_NEGATIVE == wd2_r[SENSE_NEG_BIT])
    else $error("sense polarity wrong");
  limit_code_a: assert property (oc_wr |-> ##2 CURRENT_LIMIT_UA == ua_of(wd2_r[7:5]))
    else $error("limit value wrong");
  range_bit_a: assert property (oc_wr |-> ##2 CS_RANGE_500MV == wd2_r[RANGE_SEL_BIT])
    else $error("range select wrong");
  fault_clear_a: assert property ($fell(OVERTEMP_FAULT_FLAG) |->
    $past(THERMAL_VALID) && $past(THERMAL_SENSOR) > $past(TEMP_FAULT_LIMIT))
    else $error("fault flag cleared too early");
  trim_valid_a: assert property (SAMPLE_VALID |=> TRIMMED_VALID)
    else $error("trimmed sample missing");
  bal_enable_a: assert property (REG_WR && REG_ADDR == PHASE_BAL_GAIN_ADDR
    |=> BALANCE_ACTIVE == wd1_r[BAL_ENABLE_BIT])
    else $error("balance enable wrong");
  bal_reset_a: assert property (!BALANCE_ACTIVE |=> BALANCE_CORRECTION == '0)
    else $error("integrator not reset");
  trip_cause_a: assert property ($rose(SWITCH_DISABLE) |->
    $past(CS_ABOVE_LIMIT) && $past(CS_ABOVE_LIMIT, 5))
    else $error("trip without held overcurrent");
  trip_hold_a: assert property (SWITCH_DISABLE && !SWITCH_CYCLE_START
    |=> SWITCH_DISABLE)
    else $error("shutdown ended before cycle start");
  low_power_off_a: assert property (!SMART_VOUT_EN |=> !LOW_POWER_MODE)
    else $error("low power with feature off");
  cover property (REG_WR_REFUSED);
  cover property ($rose(SWITCH_DISABLE));
  cover property ($fell(OVERTEMP_FAULT_FLAG));
endmodule : pfc_regs_properties

bind pfc_protection_trim_regs pfc_regs_properties #(.TEMP_W(TEMP_W), .INTEG_W(INTEG_W)) u_props (
  .CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RVALID, .REG_WR_REFUSED,
  .TRIM_UNLOCK, .CS_ABOVE_LIMIT, .SWITCH_CYCLE_START, .SWITCH_DISABLE, .SENSE_NEGATIVE,
  .CURRENT_LIMIT_UA, .CS_RANGE_500MV, .THERMAL_SENSOR, .THERMAL_VALID, .TEMP_FAULT_LIMIT,
  .OVERTEMP_FAULT_FLAG, .SAMPLE_VALID, .TRIMMED_VALID, .BALANCE_CORRECTION, .BALANCE_ACTIVE,
  .SMART_VOUT_EN, .LOW_POWER_MODE);

// ===== testbench/tb_top.sv
// Self-checking testbench for the protection and trim register group
`timescale 1ns/1ps
module tb_top;
  import pfc_trim_pkg::*;
  logic        CLK, RST_N, REG_WR, REG_RD, REG_RVALID, REG_WR_REFUSED, TRIM_UNLOCK;
  logic        CS_ABOVE_LIMIT, SWITCH_CYCLE_START, SWITCH_DISABLE, SENSE_NEGATIVE;
  logic        CS_RANGE_500MV, LEVEL_SHIFT_REF_EXT, THERMAL_VALID, OVERTEMP_FAULT_FLAG;
  logic        OVERTEMP_WARNING_FLAG, SAMPLE_VALID, TRIMMED_VALID, BALANCE_SAMPLE;
  logic        BALANCE_ACTIVE, SMART_VOUT_EN, HIGH_LINE, LOW_POWER_MODE;
  logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA;
  logic [1:0]  DEBOUNCE_SEL;
  logic [6:0]  CURRENT_LIMIT_UA;
  logic [7:0]  POWER_HYSTERESIS;
  logic [11:0] THERMAL_SENSOR, TEMP_FAULT_LIMIT, TEMP_WARNING_LIMIT, LINE_SAMPLE;
  logic [11:0] OUTPUT_SAMPLE, CURRENT_SAMPLE, LINE_TRIMMED, OUTPUT_TRIMMED, CURRENT_TRIMMED;
  logic [11:0] PHASE_A_CURRENT, PHASE_B_CURRENT;
  logic [23:0] BALANCE_CORRECTION;
  logic [12:0] INPUT_POWER;
  logic [10:0] LOW_LINE_LOW_POWER_TARGET, HIGH_LINE_LOW_POWER_TARGET, LOW_POWER_TARGET;
  int          err_total;
  int          checks_done;

  pfc_protection_trim_regs dut (.CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .REG_RDATA, .REG_RVALID, .REG_WR_REFUSED, .TRIM_UNLOCK, .CS_ABOVE_LIMIT,
    .SWITCH_CYCLE_START, .DEBOUNCE_SEL, .SWITCH_DISABLE, .SENSE_NEGATIVE, .CURRENT_LIMIT_UA,
    .CS_RANGE_500MV, .LEVEL_SHIFT_REF_EXT, .THERMAL_SENSOR, .THERMAL_VALID, .TEMP_FAULT_LIMIT,
    .TEMP_WARNING_LIMIT, .OVERTEMP_FAULT_FLAG, .OVERTEMP_WARNING_FLAG, .LINE_SAMPLE,
    .OUTPUT_SAMPLE, .CURRENT_SAMPLE, .SAMPLE_VALID, .LINE_TRIMMED, .OUTPUT_TRIMMED,
    .CURRENT_TRIMMED, .TRIMMED_VALID, .PHASE_A_CURRENT, .PHASE_B_CURRENT, .BALANCE_SAMPLE,
    .BALANCE_CORRECTION, .BALANCE_ACTIVE, .SMART_VOUT_EN, .INPUT_POWER, .POWER_HYSTERESIS,
    .HIGH_LINE, .LOW_LINE_LOW_POWER_TARGET, .HIGH_LINE_LOW_POWER_TARGET, .LOW_POWER_MODE,
    .LOW_POWER_TARGET);

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    if (REG_WR) REG_WR = 1'b0;
    if (REG_RD) REG_RD = 1'b0;
    repeat (n) @(negedge CLK);
  endtask : tick
  // Strobe stays up until the next transfer or wait
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    if (REG_RD) REG_RD = 1'b0;
    REG_WR = 1'b1;
    @(negedge CLK);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
    REG_ADDR = a;
    if (REG_WR) REG_WR = 1'b0;
    REG_RD = 1'b1;
    @(negedge CLK);
    chk("read valid", 32'h1, REG_RVALID);
    chk(what, exp, REG_RDATA);
  endtask : rd
  task automatic t_reset;
    for (int i = 0; i < 7; i++) rd(FAST_OC_SETTING_ADDR + 16'(i), 16'h0000, "reset value");
    chk("limit ua", 32'h14, CURRENT_LIMIT_UA);
    wr(16'hfe50, 16'hffff);
    rd(16'hfe50, 16'h0000, "unmapped");
    $display("test reset done");
  endtask : t_reset
  task automatic t_oc_setting;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(FAST_OC_SETTING_ADDR, {8'hff, c, 3'h7, c[0], !c[0]});
      tick(1);
      rd(FAST_OC_SETTING_ADDR, {8'h00, c, 3'h0, c[0], !c[0]}, "oc setting");
      chk("sense negative", c[2], SENSE_NEGATIVE);
      chk("limit ua", 7'h14 + 7'h14 * {5'h00, c[1:0]} + (c[2] ? 7'h28 : 7'h00),
          CURRENT_LIMIT_UA);
      chk("range 500mv", c[0], CS_RANGE_500MV);
      chk("ref external", !c[0], LEVEL_SHIFT_REF_EXT);
    end
    $display("test oc setting done");
  endtask : t_oc_setting
  task automatic t_trim;
    TRIM_UNLOCK = 1'b0;
    wr(LINE_GAIN_TRIM_ADDR, 16'h0085);
    chk("refused", 32'h1, REG_WR_REFUSED);
    rd(LINE_GAIN_TRIM_ADDR, 16'h0000, "locked trim");
    TRIM_UNLOCK = 1'b1;
    wr(LINE_GAIN_TRIM_ADDR, 16'hff85);
    chk("refused", 32'h0, REG_WR_REFUSED);
    wr(OUTPUT_GAIN_TRIM_ADDR, 16'h000a);
    wr(CURRENT_GAIN_TRIM_ADDR, 16'h0081);
    rd(LINE_GAIN_TRIM_ADDR, 16'h0085, "line trim");
    {LINE_SAMPLE, OUTPUT_SAMPLE, CURRENT_SAMPLE} = {3{12'h400}};
    SAMPLE_VALID = 1'b1;
    tick(1);
    SAMPLE_VALID = 1'b0;
    chk("trim valid", 32'h1, TRIMMED_VALID);
    chk("line trimmed", 32'h3fb, LINE_TRIMMED);
    chk("output trimmed", 32'h40a, OUTPUT_TRIMMED);
    chk("current trimmed", 32'h3ff, CURRENT_TRIMMED);
    $display("test trim done");
  endtask : t_trim
  task automatic temp(input logic [11:0] v, input logic f, input logic w);
    THERMAL_SENSOR = v;
    THERMAL_VALID = 1'b1;
    tick(1);
    THERMAL_VALID = 1'b0;
    tick(1);
    chk("fault flag", f, OVERTEMP_FAULT_FLAG);
    chk("warning flag", w, OVERTEMP_WARNING_FLAG);
  endtask : temp
  task automatic t_temp;
    wr(TEMP_HYSTERESIS_ADDR, 16'h0008);
    TEMP_FAULT_LIMIT = 12'h064;
    TEMP_WARNING_LIMIT = 12'h0c8;
    temp(12'h032, 1'b1, 1'b1);
    temp(12'h06c, 1'b1, 1'b1);
    temp(12'h06d, 1'b0, 1'b1);
    temp(12'h0d0, 1'b0, 1'b1);
    temp(12'h0d1, 1'b0, 1'b0);
    $display("test temperature done");
  endtask : t_temp
  task automatic bal(input logic [11:0] a, input logic [11:0] b, input logic [23:0] exp);
    {PHASE_A_CURRENT, PHASE_B_CURRENT} = {a, b};
    BALANCE_SAMPLE = 1'b1;
    tick(1);
    BALANCE_SAMPLE = 1'b0;
    chk("balance correction", exp, BALANCE_CORRECTION);
  endtask : bal
  task automatic t_balance;
    wr(PHASE_BAL_GAIN_ADDR, 16'h0083);
    chk("balance active", 32'h1, BALANCE_ACTIVE);
    bal(12'h00a, 12'h004, 24'h000012);
    wr(PHASE_BAL_GAIN_ADDR, 16'h007f);
    tick(1);
    chk("balance cleared", 32'h0, BALANCE_CORRECTION);
    rd(PHASE_BAL_GAIN_ADDR, 16'h007f, "balance gain");
    wr(PHASE_BAL_GAIN_ADDR, 16'h00ff);
    bal(12'h005, 12'h004, 24'h00007f);
    $display("test balance done");
  endtask : t_balance
  task automatic lp(input logic [12:0] p, input logic m, input logic [10:0] t);
    INPUT_POWER = p;
    tick(2);
    chk("low power mode", m, LOW_POWER_MODE);
    chk("low power target", t, LOW_POWER_TARGET);
  endtask : lp
  task automatic t_low_power;
    wr(LOW_POWER_THRESH_ADDR, 16'hffff);
    rd(LOW_POWER_THRESH_ADDR, 16'h1fff, "threshold");
    wr(LOW_POWER_THRESH_ADDR, 16'h03e8);
    {LOW_LINE_LOW_POWER_TARGET, HIGH_LINE_LOW_POWER_TARGET} = {11'h123, 11'h456};
    POWER_HYSTERESIS = 8'h0a;
    SMART_VOUT_EN = 1'b1;
    lp(13'h03e7, 1'b1, 11'h123);
    HIGH_LINE = 1'b1;
    lp(13'h03f2, 1'b1, 11'h456);
    lp(13'h03f3, 1'b0, 11'h456);
    lp(13'h03e7, 1'b1, 11'h456);
    SMART_VOUT_EN = 1'b0;
    lp(13'h03e7, 1'b0, 11'h456);
    $display("test low power done");
  endtask : t_low_power
  task automatic t_trip;
    for (int s = 0; s < 4; s++) begin
      DEBOUNCE_SEL = 2'(s);
      CS_ABOVE_LIMIT = 1'b1;
      tick(DEBOUNCE_CYC[s]);
      chk("early trip", 32'h0, SWITCH_DISABLE);
      tick(1);
      chk("trip", 32'h1, SWITCH_DISABLE);
      CS_ABOVE_LIMIT = 1'b0;
      tick(3);
      chk("shutdown held", 32'h1, SWITCH_DISABLE);
      SWITCH_CYCLE_START = 1'b1;
      tick(1);
      SWITCH_CYCLE_START = 1'b0;
      chk("shutdown released", 32'h0, SWITCH_DISABLE);
    end
    $display("test overcurrent done");
  endtask : t_trip
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  initial begin
    err_total = 0;
    checks_done = 0;
    {RST_N, REG_WR, REG_RD, TRIM_UNLOCK, CS_ABOVE_LIMIT, SWITCH_CYCLE_START, DEBOUNCE_SEL,
     THERMAL_VALID, SAMPLE_VALID, BALANCE_SAMPLE, SMART_VOUT_EN, HIGH_LINE, REG_ADDR,
     REG_WDATA, POWER_HYSTERESIS, THERMAL_SENSOR, TEMP_FAULT_LIMIT, TEMP_WARNING_LIMIT,
     LINE_SAMPLE, OUTPUT_SAMPLE, CURRENT_SAMPLE, PHASE_A_CURRENT, PHASE_B_CURRENT,
     INPUT_POWER, LOW_LINE_LOW_POWER_TARGET, HIGH_LINE_LOW_POWER_TARGET} = '0;
    tick(16);
    RST_N = 1'b1;
    t_reset();
    t_oc_setting();
    t_trim();
    t_temp();
    t_balance();
    t_low_power();
    t_trip();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    give_verdict();
  end
endmodule : tb_top
